// File: design/remote_input_command_decoder.sv
// Remote input command decoder: line mapping, debounce, edge detect, gating
//
// How it works
// - Commands issue only when their preconditions hold.
// - Every function maps to any configured line.
// - Sixteen standard lines plus extension port lines.
// - Manipulator bits value v selects manipulator v+1.
// - Select strobe latches manipulator bits as target.
// - Group bits decode directly as 0 to 15.
// - START launches only the selected group.
// - Motor-on powers the targeted manipulator.
// - Motor-off unpowers the targeted manipulator.
// - Calibrate starts origin initialisation of target.
// - Home moves targeted manipulator home.
// - Pause puts the whole controller paused.
// - Reset clears faults, interrupts all tasks.
// - Recover cancels e-stop, restores prior states.
// - Restart terminates tasks, restarts background/main.
// - Abort-all ends ordinary tasks, keeps background.
// - Ready ends tasks except recovery and background.
`timescale 1ns/1ps
module remote_input_command_decoder
  import remote_cmd_pkg::*;
#(
  parameter int DEB_COUNT = DEB_CYCLES             // Debounce length in cycles
) (
  input  wire logic                                   sys_clk,
  input  wire logic                                   rst,
  input  wire logic [STD_LINES-1:0]                   std_in,
  input  wire logic [EXT_LINES-1:0]                   ext_in,
  input  wire logic [NUM_FUNCS-1:0][LINE_SEL_W-1:0]   line_map,
  input  cmd_cond_t                                   cond,
  output cmd_strobe_t                                 cmd,
  output logic [MNP_SEL_W-1:0]                        target_mnp,
  output logic [GRP_W-1:0]                            start_group,
  output logic [NUM_FUNCS-1:0]                        func_level
);

  // Complete register state of the block
  typedef struct packed {
    logic [TOTAL_LINES-1:0]                  sync1;    // First synchroniser stage
    logic [TOTAL_LINES-1:0]                  sync2;    // Second synchroniser stage
    logic [NUM_FUNCS-1:0]                    stable;   // Debounced function levels
    logic [NUM_FUNCS-1:0][DEB_CNT_W-1:0]     cnt;      // Per-function debounce timers
    cmd_strobe_t                             cmd;      // Registered strobes
    logic [MNP_SEL_W-1:0]                    target;   // Target manipulator 1..16
    logic [GRP_W-1:0]                        group;    // Group captured at START
  } state_t;

  state_t s_q;                                     // Current state
  state_t s_d;                                     // Next state

  logic [TOTAL_LINES-1:0] lines;                   // Synchronised line vector
  logic [NUM_FUNCS-1:0]   raw;                     // Mapped raw function levels
  logic [NUM_FUNCS-1:0]   rise;                    // Debounced rising edges
  logic [MNP_W-1:0]       mnp_bits;                // Debounced manipulator bits
  logic [GRP_W-1:0]       grp_bits;                // Debounced group bits

  localparam logic [DEB_CNT_W-1:0] DEB_LAST = DEB_CNT_W'(DEB_COUNT - 1);
  localparam logic [MNP_SEL_W-1:0] TARGET_RST = MNP_SEL_W'(1);
  localparam logic [LINE_SEL_W-1:0] LINE_LAST = LINE_SEL_W'(TOTAL_LINES - 1);

  // Pick one synchronised line by number; out-of-range numbers read low
  function automatic logic pick_line(input logic [TOTAL_LINES-1:0] v,
                                     input logic [LINE_SEL_W-1:0]  n);
    pick_line = (n > LINE_LAST) ? 1'b0 : v[n];
  endfunction

  // Manipulator number from binary bits, offset by one
  function automatic logic [MNP_SEL_W-1:0] mnp_decode(input logic [MNP_W-1:0] b);
    mnp_decode = MNP_SEL_W'({1'b0, b}) + TARGET_RST;
  endfunction

  // Standard lines are 0..15, extension lines follow
  assign lines = s_q.sync2;

  // Route each function from its configured line number
  always_comb begin
    for (int f = 0; f < NUM_FUNCS; f++) begin
      raw[f] = pick_line(lines, line_map[f]);
    end
  end

  // Debounced edge and field extraction
  assign rise     = s_d.stable & ~s_q.stable;
  assign mnp_bits = s_d.stable[F_MNP0 +: MNP_W];
  assign grp_bits = s_d.stable[F_GRP0 +: GRP_W];

  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Two-stage synchroniser on every pin
    s_d.sync1 = {ext_in, std_in};
    s_d.sync2 = s_q.sync1;
    // Debounce: level accepted only after holding for the full time
    for (int f = 0; f < NUM_FUNCS; f++) begin
      if (raw[f] == s_q.stable[f]) begin
        s_d.cnt[f] = '0;                           // Agreement resets timer
      end else if (s_q.cnt[f] == DEB_LAST) begin
        s_d.cnt[f]    = '0;
        s_d.stable[f] = raw[f];
      end else begin
        s_d.cnt[f] = s_q.cnt[f] + DEB_CNT_W'(1);
      end
    end
    // Target latched while select strobe level is asserted
    if (s_d.stable[F_SEL_MNP]) begin
      s_d.target = mnp_decode(mnp_bits);
    end
    // Command strobes, each gated by its precondition
    s_d.cmd.motor_on             = rise[F_MOTOR_ON]  & cond.motor_on_ok;
    s_d.cmd.motor_off            = rise[F_MOTOR_OFF] & cond.motor_off_ok;
    s_d.cmd.origin_calibrate_req = rise[F_CALIB]     & cond.calib_ok;
    s_d.cmd.home                 = rise[F_HOME]      & cond.home_ok;
    s_d.cmd.start                = rise[F_START]     & cond.start_ok;
    s_d.cmd.pause                = rise[F_PAUSE]     & cond.pause_ok;
    s_d.cmd.reset                = rise[F_RESET]     & cond.reset_ok;
    s_d.cmd.recover              = rise[F_RECOVER]   & cond.recover_ok;
    s_d.cmd.restart              = rise[F_RESTART]   & cond.restart_ok;
    s_d.cmd.abort_all            = rise[F_ABORT]     & cond.abort_ok;
    s_d.cmd.ready                = rise[F_READY]     & cond.ready_ok;
    // Group captured with the accepted START edge
    if (rise[F_START] && cond.start_ok) begin
      s_d.group = grp_bits;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.target <= TARGET_RST;                    // Manipulator 1 after reset
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flops
  assign cmd         = s_q.cmd;
  assign target_mnp  = s_q.target;
  assign start_group = s_q.group;
  assign func_level  = s_q.stable;

endmodule

// File: inc/remote_cmd_pkg.sv
// Shared constants and carrier types for the remote input command decoder
package remote_cmd_pkg;

  // Port geometry
  localparam int STD_LINES   = 16;                     // Standard port input lines
  localparam int EXT_LINES   = 64;                     // Extension port input lines
  localparam int TOTAL_LINES = STD_LINES + EXT_LINES;  // All selectable lines
  localparam int LINE_SEL_W  = 7;                      // Width of a line number
  localparam int NUM_FUNCS   = 21;                     // Assignable remote functions

  // Function slots in the line-map
  localparam int F_MOTOR_ON  = 0;
  localparam int F_MOTOR_OFF = 1;
  localparam int F_CALIB     = 2;
  localparam int F_HOME      = 3;
  localparam int F_MNP0      = 4;                      // Mnp bits occupy 4..7
  localparam int F_SEL_MNP   = 8;
  localparam int F_START     = 9;
  localparam int F_PAUSE     = 10;
  localparam int F_RESET     = 11;
  localparam int F_GRP0      = 12;                     // Group bits occupy 12..15
  localparam int F_RECOVER   = 16;
  localparam int F_RESTART   = 17;
  localparam int F_ABORT     = 18;
  localparam int F_READY     = 19;
  localparam int F_SPARE     = 20;

  // Field widths
  localparam int MNP_W = 4;
  localparam int GRP_W = 4;
  localparam int MNP_SEL_W = 5;                        // Holds manipulator 1..16

  // Debounce time and cycle count at 250 MHz
  localparam int DEB_TIME_MS = 10;
  localparam int CLK_KHZ     = 250000;
  localparam int DEB_CYCLES  = DEB_TIME_MS * CLK_KHZ;
  localparam int DEB_CNT_W   = 22;

  // One-cycle command strobes
  typedef struct packed {
    logic motor_on;
    logic motor_off;
    logic origin_calibrate_req;
    logic home;
    logic start;
    logic pause;
    logic reset;
    logic recover;
    logic restart;
    logic abort_all;
    logic ready;
  } cmd_strobe_t;

  // Controller conditions that gate each command
  typedef struct packed {
    logic motor_on_ok;
    logic motor_off_ok;
    logic calib_ok;
    logic home_ok;
    logic start_ok;
    logic pause_ok;
    logic reset_ok;
    logic recover_ok;
    logic restart_ok;
    logic abort_ok;
    logic ready_ok;
  } cmd_cond_t;

endpackage

// File: sim/remote_decoder_properties.sv
// Port checker for the remote input command decoder
`timescale 1ns/1ps
module remote_decoder_properties
  import remote_cmd_pkg::*;
(
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire cmd_cond_t            cond,
  input wire cmd_strobe_t          cmd,
  input wire logic [MNP_SEL_W-1:0] target_mnp,
  input wire logic [GRP_W-1:0]     start_group,
  input wire logic [NUM_FUNCS-1:0] func_level
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_single; cmd.motor_on |=> !cmd.motor_on; endproperty
  a_single: assert property (p_single) else $error("strobe too long");
  property p_gate; cmd.motor_off |-> $past(cond.motor_off_ok); endproperty
  a_gate: assert property (p_gate) else $error("strobe while refused");
  property p_edge; cmd.home |-> $rose(func_level[F_HOME]); endproperty
  a_edge: assert property (p_edge) else $error("strobe without edge");
  property p_pause; cmd.pause |-> $past(cond.pause_ok) && func_level[F_PAUSE]; endproperty
  a_pause: assert property (p_pause) else $error("pause strobe wrong");
  property p_grp; cmd.start && $stable(func_level[15:12]) |-> start_group == func_level[15:12];
  endproperty
  a_grp: assert property (p_grp) else $error("group not captured");
  property p_ghold; !cmd.start |-> $stable(start_group); endproperty
  a_ghold: assert property (p_ghold) else $error("group moved");
  property p_tgt; func_level[8] && $past(func_level[8]) && $stable(func_level[7:4])
    |-> target_mnp == func_level[7:4] + 5'h1; endproperty
  a_tgt: assert property (p_tgt) else $error("target wrong");
  property p_thold; !func_level[8] && !$past(func_level[8]) |-> $stable(target_mnp); endproperty
  a_thold: assert property (p_thold) else $error("target moved");
endmodule

// File: sim/remote_sequencer.sv
// Sequencer model that drives the remote input lines
`timescale 1ns/1ps
module remote_sequencer
  import remote_cmd_pkg::*;
#(parameter int HOLD = 8)
(
  input  wire logic                   sys_clk,
  input  wire logic                   chatter,
  input  wire logic [TOTAL_LINES-1:0] want,
  output logic      [STD_LINES-1:0]   std_in,
  output logic      [EXT_LINES-1:0]   ext_in
);
  int held = 0; // Cycles since the last change
  initial {ext_in, std_in} = '0;
  // A level moves only after the previous one stood HOLD cycles, or at once while chatter is high
  always @(posedge sys_clk) begin
    held <= held + 1;
    if (want != {ext_in, std_in} && (chatter || held >= HOLD)) begin
      {ext_in, std_in} <= want;
      held <= 0;
    end
  end
endmodule

// File: sim/remote_input_command_decoder_test.sv
// Self-checking bench for the remote input command decoder
`timescale 1ns/1ps
module remote_input_command_decoder_test;
  import remote_cmd_pkg::*;
  logic sys_clk = 0, rst = 1, chatter = 0;
  logic [TOTAL_LINES-1:0] want = '0;
  logic [STD_LINES-1:0] std_in;
  logic [EXT_LINES-1:0] ext_in;
  logic [NUM_FUNCS-1:0][LINE_SEL_W-1:0] line_map = '0;
  cmd_cond_t cond = '0;
  cmd_strobe_t cmd;
  logic [MNP_SEL_W-1:0] target_mnp;
  logic [GRP_W-1:0] start_group;
  logic [NUM_FUNCS-1:0] func_level;
  logic [3:0] v;
  int errors = 0, n_tests = 0, b, base, hits [11];
  int slot [11] = '{F_MOTOR_ON, F_MOTOR_OFF, F_CALIB, F_HOME, F_START, F_PAUSE,
                    F_RESET, F_RECOVER, F_RESTART, F_ABORT, F_READY};
  always #2 sys_clk = ~sys_clk;
  remote_sequencer #(.HOLD(8)) seq (.sys_clk(sys_clk), .chatter(chatter), .want(want),
    .std_in(std_in), .ext_in(ext_in));
  remote_input_command_decoder #(.DEB_COUNT(4)) DUT (.sys_clk(sys_clk), .rst(rst),
    .std_in(std_in), .ext_in(ext_in), .line_map(line_map), .cond(cond), .cmd(cmd),
    .target_mnp(target_mnp), .start_group(start_group), .func_level(func_level));
  // Strobe tally, first entry is motor on
  always @(posedge sys_clk) if (!rst) for (int i = 0; i < 11; i++) hits[i] <= hits[i] + cmd[10-i];
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One pulse on a mapped line, then a quiet gap
  task automatic pulse(int f, int hi);
    want[line_map[f]] <= 1'b1;
    repeat (hi) @(posedge sys_clk);
    want[line_map[f]] <= 1'b0;
    repeat (30) @(posedge sys_clk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    test_done();
  end
  initial begin
    base = $urandom(25);
    base = $urandom % 60;
    @(posedge sys_clk);
    for (int f = 0; f < NUM_FUNCS; f++) line_map[f] <= LINE_SEL_W'(base + f);
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check(target_mnp, 1);
    check(start_group, 0);
    // Every command accepted, then every command refused
    for (int i = 0; i < 22; i++) begin
      b = hits[i%11];
      cond <= (i < 11) ? '1 : '0;
      pulse(slot[i%11], 12);
      check(hits[i%11] - b, i < 11);
    end
    $display("command test done");
    chatter <= 1'b1;
    cond <= '1;
    b = hits[5];
    pulse(F_PAUSE, 2);
    check(hits[5] - b, 0);
    chatter <= 1'b0;
    $display("short pulse test done");
    // Manipulator select and group capture, corner value first
    for (int r = 0; r < 4; r++) begin
      v = (r == 0) ? 4'hf : 4'($urandom);
      for (int k = 0; k < 4; k++) want[line_map[F_MNP0+k]] <= v[k];
      repeat (20) @(posedge sys_clk);
      pulse(F_SEL_MNP, 12);
      check(target_mnp, v + 5'h1);
      for (int k = 0; k < 4; k++) want[line_map[F_MNP0+k]] <= ~v[k];
      for (int k = 0; k < 4; k++) want[line_map[F_GRP0+k]] <= v[k];
      repeat (20) @(posedge sys_clk);
      check(target_mnp, v + 5'h1);
      pulse(F_START, 12);
      check(start_group, v);
    end
    $display("select and group test done");
    test_done();
  end
endmodule
bind remote_input_command_decoder remote_decoder_properties chk (.sys_clk(sys_clk), .rst(rst),
  .cond(cond), .cmd(cmd), .target_mnp(target_mnp), .start_group(start_group),
  .func_level(func_level));
